// ---- core/fifo_prog_pkg.sv ----
// shared constants for the offset-programmable fifo and its port controller
package fifo_prog_pkg;
    localparam int DATA_W        = 36;
    localparam int DEPTH_DEFAULT = 512;
    localparam int PRESET_SMALL  = 8;
    localparam int PRESET_LARGE  = 64;
    localparam int RST_EDGES     = 4;
    localparam int IR_DELAY      = 2;
    localparam int SEL_HOLD      = 4;

    // flag select codes {sel1, sel0} at reset release
    localparam logic [1:0] MODE_PARALLEL = 2'h0;
    localparam logic [1:0] MODE_PRESET8  = 2'h1;
    localparam logic [1:0] MODE_PRESET64 = 2'h2;
    localparam logic [1:0] MODE_SERIAL   = 2'h3;

    // controller register offsets
    localparam logic [7:0] REG_CTRL   = 8'h00;
    localparam logic [7:0] REG_OFFSET = 8'h04;
    localparam logic [7:0] REG_TXDATA = 8'h08;
    localparam logic [7:0] REG_RXDATA = 8'h0C;
    localparam logic [7:0] REG_STATUS = 8'h10;
    localparam logic [7:0] REG_HIGH   = 8'h14;

    localparam int CTRL_START   = 0;
    localparam int CTRL_MODE_LO = 1;
    localparam int OFS_X_LO     = 0;
    localparam int OFS_Y_LO     = 16;
    localparam logic [1:0] CTRL_MODE_RST = MODE_PRESET64;
endpackage : fifo_prog_pkg

// ---- core/fifo_link_if.sv ----
// pin bundle between the fifo device and its port controller
`timescale 1ns/1ps
interface fifo_link_if;
    import fifo_prog_pkg::*;
    logic              rst_n;
    logic              flag_sel0_serial_data;
    logic              flag_sel1_serial_enable_n;
    logic              csa_n;
    logic              wra;
    logic              ena;
    logic              mba;
    logic [DATA_W-1:0] port_a_bus;
    logic              csb_n;
    logic              wrb;
    logic              enb;
    logic              mbb;
    logic [DATA_W-1:0] port_b_bus;
    logic              write_space_flag;
    logic              read_valid;
    logic              almost_empty_n;
    logic              almost_full_n;
    logic              mail_full_1_n;
    logic              mail_full_2_n;

    modport device (
        input  rst_n, flag_sel0_serial_data, flag_sel1_serial_enable_n,
        input  csa_n, wra, ena, mba, port_a_bus, csb_n, wrb, enb, mbb,
        output port_b_bus, write_space_flag, read_valid,
        output almost_empty_n, almost_full_n, mail_full_1_n, mail_full_2_n
    );
    modport host (
        output rst_n, flag_sel0_serial_data, flag_sel1_serial_enable_n,
        output csa_n, wra, ena, mba, port_a_bus, csb_n, wrb, enb, mbb,
        input  port_b_bus, write_space_flag, read_valid,
        input  almost_empty_n, almost_full_n, mail_full_1_n, mail_full_2_n
    );
endinterface : fifo_link_if

// ---- core/reset_release_sync.sv ----
// asynchronous assert, synchronous release of the fifo reset pin
`timescale 1ns/1ps
module reset_release_sync (
    input  wire logic clk,
    input  wire logic rst_pin_n,
    output logic      rst_sync_n
);
    logic meta_ff;
    logic hold_ff;

    // the pin may move at any moment; only the second stage is used
    always_ff @(posedge clk or negedge rst_pin_n) begin
        if (!rst_pin_n) begin
            meta_ff <= 1'b0;
            hold_ff <= 1'b0;
        end else begin
            meta_ff <= 1'b1;
            hold_ff <= meta_ff;
        end
    end

    assign rst_sync_n = hold_ff;
endmodule : reset_release_sync

// ---- core/fifo_device.sv ----
// first-word-fall-through fifo with programmable almost-empty/almost-full offsets
//
// Summary of operation
// - controller holds reset low four edges minimum
// - reset accepted at any moment, asynchronously
// - reset clears pointers, flags low, almost-full high
// - reset forces both mailbox full flags high
// - preset/parallel: write space rises after two edges
// - controller resets fifo before writing any data
// - first word appears on outputs unrequested
// - following words need an explicit read
// - two offset registers, almost-empty and almost-full
// - flag selects sampled at reset release
// - 11 serial, 10 preset 64, 01 preset 8, 00 parallel
// - preset value loads both offsets automatically
// - parallel: first write almost-full, second almost-empty
// - parallel offsets from low port A bits
// - offset values between one and depth minus four
// - after both offsets loaded, writes store data
// - serial: one bit per edge while enable low
// - serial needs twice the offset width bits
// - serial stream almost-full msb first, almost-empty lsb last
// - serial: write space rises edge after last bit
// - writes ignored while write space flag low
`timescale 1ns/1ps
module fifo_device
    import fifo_prog_pkg::*;
#(
    parameter int DEPTH = DEPTH_DEFAULT
) (
    input  wire logic                     pclk,
    fifo_link_if.device                   link,
    output logic [$clog2(DEPTH):0]        fill_level_ff
);
    localparam int OFS_W = $clog2(DEPTH);
    localparam int SER_BITS = 2 * OFS_W;

    initial begin
        if (DEPTH != 512 && DEPTH != 1024 && DEPTH != 2048) begin
            $error("fifo_device: DEPTH must be 512, 1024 or 2048");
        end
    end

    typedef enum logic [2:0] {
        CFG_CAPTURE,
        CFG_WAIT,
        CFG_PAR_Y,
        CFG_PAR_X,
        CFG_SERIAL,
        CFG_RUN
    } cfg_state_t;

    ////////////////////
    // reset release

    logic rst_n;

    reset_release_sync u_rst_sync (
        .clk        (pclk),
        .rst_pin_n  (link.rst_n),
        .rst_sync_n (rst_n)
    );

    ////////////////////
    // offset programming

    cfg_state_t        cfg_ff;
    cfg_state_t        nxt_cfg;
    cfg_state_t        after_wait_ff;
    logic [1:0]        wait_cnt_ff;
    logic [4:0]        ser_cnt_ff;
    logic [OFS_W-1:0]  x_ofs_ff;
    logic [OFS_W-1:0]  y_ofs_ff;
    logic [1:0]        sel_mode;
    logic              write_req;
    logic              write_fire;
    logic              ser_shift;

    assign sel_mode   = {link.flag_sel1_serial_enable_n, link.flag_sel0_serial_data};
    assign write_req  = !link.csa_n && link.wra && link.ena && !link.mba;
    assign write_fire = write_req && link.write_space_flag;
    assign ser_shift  = (cfg_ff == CFG_SERIAL) && !link.flag_sel1_serial_enable_n
                        && (ser_cnt_ff != 5'(SER_BITS));

    always_comb begin
        nxt_cfg = cfg_ff;
        case (cfg_ff)
            CFG_CAPTURE: begin
                nxt_cfg = (sel_mode == MODE_SERIAL) ? CFG_SERIAL : CFG_WAIT;
            end
            CFG_WAIT: begin
                if (wait_cnt_ff == 2'(IR_DELAY - 1)) begin
                    nxt_cfg = after_wait_ff;
                end
            end
            CFG_PAR_Y: begin
                if (write_fire) begin
                    nxt_cfg = CFG_PAR_X;
                end
            end
            CFG_PAR_X: begin
                if (write_fire) begin
                    nxt_cfg = CFG_RUN;
                end
            end
            CFG_SERIAL: begin
                // leave only on the edge after the last bit
                if (ser_cnt_ff == 5'(SER_BITS)) begin
                    nxt_cfg = CFG_RUN;
                end
            end
            CFG_RUN: nxt_cfg = CFG_RUN;
            default: nxt_cfg = CFG_CAPTURE;
        endcase
    end

    always_ff @(posedge pclk or negedge rst_n) begin
        if (!rst_n) begin
            cfg_ff <= CFG_CAPTURE;
        end else begin
            cfg_ff <= nxt_cfg;
        end
    end

    // mode is caught on the first edge after the synchronised release
    always_ff @(posedge pclk or negedge rst_n) begin
        if (!rst_n) begin
            after_wait_ff <= CFG_RUN;
            wait_cnt_ff   <= 2'h0;
        end else if (cfg_ff == CFG_CAPTURE) begin
            after_wait_ff <= (sel_mode == MODE_PARALLEL) ? CFG_PAR_Y : CFG_RUN;
            wait_cnt_ff   <= 2'h0;
        end else if (cfg_ff == CFG_WAIT) begin
            wait_cnt_ff <= wait_cnt_ff + 2'h1;
        end
    end

    // offsets survive until a new reset; no other path writes them
    always_ff @(posedge pclk or negedge rst_n) begin
        if (!rst_n) begin
            x_ofs_ff   <= OFS_W'(PRESET_LARGE);
            y_ofs_ff   <= OFS_W'(PRESET_LARGE);
            ser_cnt_ff <= 5'h0;
        end else begin
            if (cfg_ff == CFG_CAPTURE) begin
                case (sel_mode)
                    MODE_PRESET8: begin
                        x_ofs_ff <= OFS_W'(PRESET_SMALL);
                        y_ofs_ff <= OFS_W'(PRESET_SMALL);
                    end
                    MODE_PRESET64: begin
                        x_ofs_ff <= OFS_W'(PRESET_LARGE);
                        y_ofs_ff <= OFS_W'(PRESET_LARGE);
                    end
                    default: begin
                    end
                endcase
            end else if (cfg_ff == CFG_PAR_Y && write_fire) begin
                y_ofs_ff <= link.port_a_bus[OFS_W-1:0];
            end else if (cfg_ff == CFG_PAR_X && write_fire) begin
                x_ofs_ff <= link.port_a_bus[OFS_W-1:0];
            end else if (ser_shift) begin
                // y msb enters first and ends at the top of the chain
                {y_ofs_ff, x_ofs_ff} <= {y_ofs_ff[OFS_W-2:0], x_ofs_ff,
                                         link.flag_sel0_serial_data};
                ser_cnt_ff <= ser_cnt_ff + 5'h1;
            end
        end
    end

    ////////////////////
    // memory and fall-through output

    logic [DATA_W-1:0] mem [DEPTH];
    logic [OFS_W-1:0]  wr_ptr_ff;
    logic [OFS_W-1:0]  rd_ptr_ff;
    logic [OFS_W:0]    count_ff;
    logic [OFS_W:0]    nxt_count;
    logic              store;
    logic              read_fire;
    logic              load_out;
    logic              nxt_valid;
    logic              accepting;
    logic [DATA_W-1:0] dout_ff;
    logic              ir_ff;
    logic              or_ff;
    logic              ae_n_ff;
    logic              af_n_ff;
    logic              mail_full_1_n_n_ff;
    logic              mail_full_2_n_n_ff;

    assign store     = write_fire && (cfg_ff == CFG_RUN);
    assign read_fire = !link.csb_n && link.wrb && link.enb && !link.mbb && or_ff;
    // empty output register pulls the next word without a request
    assign load_out  = (count_ff != '0) && (!or_ff || read_fire);
    assign nxt_valid = load_out || (or_ff && !read_fire);
    assign nxt_count = count_ff + (OFS_W+1)'(store) - (OFS_W+1)'(load_out);
    assign accepting = (nxt_cfg == CFG_PAR_Y) || (nxt_cfg == CFG_PAR_X)
                       || (nxt_cfg == CFG_RUN);

    always_ff @(posedge pclk) begin
        if (store) begin
            mem[wr_ptr_ff] <= link.port_a_bus;
        end
    end

    always_ff @(posedge pclk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
            count_ff  <= '0;
        end else begin
            if (store) begin
                wr_ptr_ff <= wr_ptr_ff + OFS_W'(1);
            end
            if (load_out) begin
                rd_ptr_ff <= rd_ptr_ff + OFS_W'(1);
            end
            count_ff <= nxt_count;
        end
    end

    always_ff @(posedge pclk or negedge rst_n) begin
        if (!rst_n) begin
            dout_ff <= '0;
            or_ff   <= 1'b0;
        end else begin
            if (load_out) begin
                dout_ff <= mem[rd_ptr_ff];
            end
            or_ff <= nxt_valid;
        end
    end

    ////////////////////
    // flags

    // flags are taken from next-state values so they never lag a transfer
    always_ff @(posedge pclk or negedge rst_n) begin
        if (!rst_n) begin
            ir_ff     <= 1'b0;
            ae_n_ff   <= 1'b0;
            af_n_ff   <= 1'b1;
            mail_full_1_n_n_ff <= 1'b1;
            mail_full_2_n_n_ff <= 1'b1;
        end else begin
            ir_ff     <= accepting && (nxt_count < (OFS_W+1)'(DEPTH));
            ae_n_ff   <= (nxt_count + (OFS_W+1)'(nxt_valid)) > {1'b0, x_ofs_ff};
            af_n_ff   <= nxt_count < ((OFS_W+1)'(DEPTH) - {1'b0, y_ofs_ff});
            mail_full_1_n_n_ff <= 1'b1;
            mail_full_2_n_n_ff <= 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge rst_n) begin
        if (!rst_n) begin
            fill_level_ff <= '0;
        end else begin
            fill_level_ff <= nxt_count;
        end
    end

    assign link.port_b_bus       = dout_ff;
    assign link.write_space_flag = ir_ff;
    assign link.read_valid       = or_ff;
    assign link.almost_empty_n   = ae_n_ff;
    assign link.almost_full_n    = af_n_ff;
    assign link.mail_full_1_n    = mail_full_1_n_n_ff;
    assign link.mail_full_2_n    = mail_full_2_n_n_ff;
endmodule : fifo_device

// ---- core/fifo_controller.sv ----
// apb-driven controller that resets, programs, writes and reads the fifo
`timescale 1ns/1ps
module fifo_controller
    import fifo_prog_pkg::*;
#(
    parameter int DEPTH = DEPTH_DEFAULT
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    fifo_link_if.host        link
);
    localparam int OFS_W = $clog2(DEPTH);
    localparam int SER_BITS = 2 * OFS_W;

    initial begin
        if (DEPTH != 512 && DEPTH != 1024 && DEPTH != 2048) begin
            $error("fifo_controller: DEPTH must be 512, 1024 or 2048");
        end
    end

    typedef enum logic [1:0] { H_IDLE, H_HOLD, H_SETTLE, H_SHIFT } host_state_t;

    host_state_t             st_ff;
    logic [4:0]              cnt_ff;
    logic [1:0]              mode_ff;
    logic [OFS_W-1:0]        x_ff;
    logic [OFS_W-1:0]        y_ff;
    logic [2*OFS_W-1:0]      sh_ff;
    logic [3:0]              tx_hi_ff;
    logic [3:0]              rx_hi_ff;
    logic                    rst_n_ff;
    logic                    sd_ff;
    logic                    sen_n_ff;
    logic                    wr_en_ff;
    logic                    rd_en_ff;
    logic [DATA_W-1:0]       wdata_ff;
    logic [31:0]             prdata_ff;
    logic                    pready_ff;
    logic                    pslverr_ff;
    logic                    access;
    logic                    commit;
    logic                    busy;
    logic                    start;

    assign access = psel && penable && !pready_ff;
    assign commit = psel && penable && pready_ff;
    assign busy   = (st_ff != H_IDLE);
    assign start  = commit && pwrite && (paddr == REG_CTRL) && pwdata[CTRL_START] && !busy;

    ////////////////////
    // reset and offset programming sequence

    // a reset is run after presetn, so no data reaches the fifo unreset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_ff    <= H_HOLD;
            cnt_ff   <= 5'h0;
            rst_n_ff <= 1'b0;
            sen_n_ff <= 1'b1;
            sd_ff    <= 1'b0;
            sh_ff    <= '0;
        end else begin
            case (st_ff)
                H_IDLE: begin
                    sd_ff    <= mode_ff[0];
                    sen_n_ff <= mode_ff[1];
                    if (start) begin
                        st_ff    <= H_HOLD;
                        cnt_ff   <= 5'h0;
                        rst_n_ff <= 1'b0;
                        sd_ff    <= pwdata[CTRL_MODE_LO];
                        sen_n_ff <= pwdata[CTRL_MODE_LO+1];
                    end
                end
                H_HOLD: begin
                    cnt_ff <= cnt_ff + 5'h1;
                    if (cnt_ff == 5'(RST_EDGES - 1)) begin
                        rst_n_ff <= 1'b1;
                        cnt_ff   <= 5'h0;
                        st_ff    <= H_SETTLE;
                    end
                end
                H_SETTLE: begin
                    // selects stay put until the device has caught them
                    cnt_ff <= cnt_ff + 5'h1;
                    if (cnt_ff == 5'(SEL_HOLD - 1)) begin
                        cnt_ff <= 5'h0;
                        if (mode_ff == MODE_SERIAL) begin
                            st_ff    <= H_SHIFT;
                            sen_n_ff <= 1'b0;
                            sd_ff    <= y_ff[OFS_W-1];
                            sh_ff    <= {y_ff[OFS_W-2:0], x_ff, 1'b0};
                        end else begin
                            st_ff <= H_IDLE;
                        end
                    end
                end
                H_SHIFT: begin
                    cnt_ff <= cnt_ff + 5'h1;
                    if (cnt_ff == 5'(SER_BITS - 1)) begin
                        sen_n_ff <= 1'b1;
                        st_ff    <= H_IDLE;
                    end else begin
                        sd_ff <= sh_ff[2*OFS_W-1];
                        sh_ff <= {sh_ff[2*OFS_W-2:0], 1'b0};
                    end
                end
                default: st_ff <= H_IDLE;
            endcase
        end
    end

    ////////////////////
    // apb slave

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_ff  <= CTRL_MODE_RST;
            x_ff     <= OFS_W'(PRESET_LARGE);
            y_ff     <= OFS_W'(PRESET_LARGE);
            tx_hi_ff <= 4'h0;
        end else if (commit && pwrite) begin
            if (start) begin
                mode_ff <= pwdata[CTRL_MODE_LO +: 2];
            end
            if (paddr == REG_OFFSET && !busy) begin
                x_ff <= pwdata[OFS_X_LO +: OFS_W];
                y_ff <= pwdata[OFS_Y_LO +: OFS_W];
            end
            if (paddr == REG_HIGH) begin
                tx_hi_ff <= pwdata[3:0];
            end
        end
    end

    // txdata writes and rxdata reads answer only when the fifo can take or give a word
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff  <= 32'h0;
        end else if (pready_ff) begin
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
        end else if (access) begin
            case (paddr)
                REG_CTRL: begin
                    pready_ff <= 1'b1;
                    prdata_ff <= {29'h0, mode_ff, 1'b0};
                end
                REG_OFFSET: begin
                    pready_ff <= 1'b1;
                    prdata_ff <= 32'({y_ff, 16'(0)}) | 32'(x_ff);
                end
                REG_TXDATA: begin
                    pready_ff <= !pwrite || (link.write_space_flag && !wr_en_ff);
                    prdata_ff <= 32'h0;
                end
                REG_RXDATA: begin
                    pready_ff <= pwrite || (link.read_valid && !rd_en_ff);
                    prdata_ff <= link.port_b_bus[31:0];
                end
                REG_STATUS: begin
                    pready_ff <= 1'b1;
                    prdata_ff <= {25'h0, link.mail_full_2_n, link.mail_full_1_n,
                                  link.almost_full_n, link.almost_empty_n,
                                  link.read_valid, link.write_space_flag, busy};
                end
                REG_HIGH: begin
                    pready_ff <= 1'b1;
                    prdata_ff <= {28'h0, rx_hi_ff};
                end
                default: begin
                    pready_ff  <= 1'b1;
                    pslverr_ff <= 1'b1;
                    prdata_ff  <= 32'h0;
                end
            endcase
        end
    end

    ////////////////////
    // port strobes, one cycle per committed transfer

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wr_en_ff <= 1'b0;
            rd_en_ff <= 1'b0;
            wdata_ff <= '0;
            rx_hi_ff <= 4'h0;
        end else begin
            wr_en_ff <= commit && pwrite && (paddr == REG_TXDATA);
            rd_en_ff <= commit && !pwrite && (paddr == REG_RXDATA);
            if (commit && pwrite && paddr == REG_TXDATA) begin
                wdata_ff <= {tx_hi_ff, pwdata};
            end
            if (commit && !pwrite && paddr == REG_RXDATA) begin
                rx_hi_ff <= link.port_b_bus[DATA_W-1:32];
            end
        end
    end

    assign prdata  = prdata_ff;
    assign pready  = pready_ff;
    assign pslverr = pslverr_ff;

    assign link.rst_n                     = rst_n_ff;
    assign link.flag_sel0_serial_data     = sd_ff;
    assign link.flag_sel1_serial_enable_n = sen_n_ff;
    assign link.csa_n                     = !wr_en_ff;
    assign link.wra                       = 1'b1;
    assign link.ena                       = wr_en_ff;
    assign link.mba                       = 1'b0;
    assign link.port_a_bus                = wdata_ff;
    assign link.csb_n                     = !rd_en_ff;
    assign link.wrb                       = 1'b1;
    assign link.enb                       = rd_en_ff;
    assign link.mbb                       = 1'b0;
endmodule : fifo_controller

// ---- testbench/fifo_link_props.sv ----
// assertions on the link between the fifo controller and the fifo device
`timescale 1ns/1ps
module fifo_link_props
    import fifo_prog_pkg::*;
(
    input wire logic              pclk,
    input wire logic              presetn,
    input wire logic              rst_n,
    input wire logic              flag_sel0_serial_data,
    input wire logic              flag_sel1_serial_enable_n,
    input wire logic              csb_n,
    input wire logic              wrb,
    input wire logic              enb,
    input wire logic              mbb,
    input wire logic [DATA_W-1:0] port_b_bus,
    input wire logic              write_space_flag,
    input wire logic              read_valid,
    input wire logic              almost_empty_n,
    input wire logic              almost_full_n,
    input wire logic              mail_full_1_n,
    input wire logic              mail_full_2_n
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire sel_ser = flag_sel0_serial_data && flag_sel1_serial_enable_n;
    wire rd_req  = !csb_n && wrb && enb && !mbb;
    ////////////////////
    sequence s_rel_fixed; $rose(rst_n) && !sel_ser; endsequence
    sequence s_rel_serial; $rose(rst_n) && sel_ser; endsequence
    property p_rst_flags;
        !rst_n |-> !write_space_flag && !read_valid && !almost_empty_n && almost_full_n;
    endproperty
    property p_mbf; mail_full_1_n && mail_full_2_n; endproperty
    property p_rst_len; $fell(rst_n) |-> !rst_n [*4]; endproperty
    property p_ir_fixed; s_rel_fixed |-> !write_space_flag [*4] ##[1:2] write_space_flag; endproperty
    // 18 bits at least, so eight low cycles is a safe floor
    property p_ir_serial; s_rel_serial |-> !write_space_flag [*8]; endproperty
    property p_sel_hold;
        $rose(rst_n) |-> $stable(flag_sel0_serial_data) && $stable(flag_sel1_serial_enable_n);
    endproperty
    property p_out_hold; read_valid && !rd_req ##1 rst_n |-> read_valid && $stable(port_b_bus);
    endproperty
    property p_ae_empty; rst_n && !read_valid |-> !almost_empty_n; endproperty
    a_rst_flags: assert property (p_rst_flags) else $error("flags wrong in reset");
    a_mbf: assert property (p_mbf) else $error("mail flag low");
    a_rst_len: assert property (p_rst_len) else $error("reset pulse short");
    a_ir_fixed: assert property (p_ir_fixed) else $error("write space timing");
    a_ir_serial: assert property (p_ir_serial) else $error("write space early");
    a_sel_hold: assert property (p_sel_hold) else $error("selects moved");
    a_out_hold: assert property (p_out_hold) else $error("output changed");
    a_ae_empty: assert property (p_ae_empty) else $error("almost empty high");
endmodule : fifo_link_props

// ---- testbench/fifo_reset_offset_program_tb.sv ----
// apb-driven bench for the controller and fifo device pair
`timescale 1ns/1ps
module fifo_reset_offset_program_tb;
    import fifo_prog_pkg::*;
    logic                           pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic [7:0]                     paddr;
    logic [31:0]                    pwdata, prdata, rdat;
    logic [$clog2(DEPTH_DEFAULT):0] fill;
    int                             mismatches, n_checks, cycles = 0;
    fifo_link_if lnk ();
    fifo_controller fifo_controller_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .link(lnk.host));
    fifo_device fifo_device_inst (.pclk(pclk), .link(lnk.device), .fill_level_ff(fill));
    fifo_link_props fifo_link_props_inst (.pclk(pclk), .presetn(presetn), .rst_n(lnk.rst_n),
        .flag_sel0_serial_data(lnk.flag_sel0_serial_data), .csb_n(lnk.csb_n),
        .flag_sel1_serial_enable_n(lnk.flag_sel1_serial_enable_n), .wrb(lnk.wrb),
        .enb(lnk.enb), .mbb(lnk.mbb), .port_b_bus(lnk.port_b_bus), .read_valid(lnk.read_valid),
        .write_space_flag(lnk.write_space_flag), .almost_empty_n(lnk.almost_empty_n),
        .almost_full_n(lnk.almost_full_n), .mail_full_1_n(lnk.mail_full_1_n),
        .mail_full_2_n(lnk.mail_full_2_n));
    ////////////////////
    task automatic stop_test;
        if (mismatches == 0 && n_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : stop_test
    task automatic chk(input string what, input logic [35:0] exp, input logic [35:0] got);
        n_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    // idle edge first: psel never set twice in a step
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rdat = prdata;
        err  = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic run_reset(input logic [1:0] mode);
        apb(1'b1, REG_CTRL, {29'h0, mode, 1'b1});
        do apb(1'b0, REG_STATUS, 32'h0); while (rdat[1] !== 1'b0);
        do apb(1'b0, REG_STATUS, 32'h0); while (rdat[1:0] !== 2'b10);
        chk("status", 36'h72, {29'h0, rdat[6:0]});
    endtask : run_reset
    task automatic t_preset;
        run_reset(MODE_PRESET8);
        apb(1'b1, REG_HIGH, 32'h5);
        apb(1'b1, REG_TXDATA, 32'hA1);
        repeat (3) @(posedge pclk);
        chk("fall through", {4'h5, 32'hA1}, lnk.port_b_bus);
        apb(1'b1, REG_TXDATA, 32'hB2);
        repeat (3) @(posedge pclk);
        chk("held word", {4'h5, 32'hA1}, lnk.port_b_bus);
        apb(1'b0, REG_RXDATA, 32'h0);
        chk("rx first", 36'hA1, {4'h0, rdat});
        apb(1'b0, REG_RXDATA, 32'h0);
        chk("rx second", 36'hB2, {4'h0, rdat});
        apb(1'b0, 8'h20, 32'h0);
        chk("unmapped", 36'h1, {35'h0, err});
    endtask : t_preset
    // set upper bits would pull almost-full low if they leaked
    task automatic t_parallel;
        run_reset(MODE_PARALLEL);
        apb(1'b1, REG_TXDATA, 32'hFFFFF005);
        apb(1'b1, REG_TXDATA, 32'hFFFFF003);
        repeat (3) @(posedge pclk);
        chk("no store", 36'h0, {35'h0, lnk.read_valid} | fill);
        chk("af width", 36'h1, {35'h0, lnk.almost_full_n});
        apb(1'b1, REG_TXDATA, 32'hC3);
        apb(1'b1, REG_TXDATA, 32'hD4);
        repeat (3) @(posedge pclk);
        chk("stored", {4'h5, 32'hC3}, lnk.port_b_bus);
        chk("fill", 36'h1, {26'h0, fill});
    endtask : t_parallel
    task automatic t_serial;
        apb(1'b1, REG_OFFSET, {16'h7, 16'h2});
        run_reset(MODE_SERIAL);
        for (int i = 0; i < 3; i++) apb(1'b1, REG_TXDATA, i);
        repeat (3) @(posedge pclk);
        chk("ae three", 36'h1, {35'h0, lnk.almost_empty_n});
        apb(1'b0, REG_RXDATA, 32'h0);
        repeat (3) @(posedge pclk);
        chk("ae two", 36'h0, {35'h0, lnk.almost_empty_n});
    endtask : t_serial
    ////////////////////
    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            stop_test;
        end
    end
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        do apb(1'b0, REG_STATUS, 32'h0); while (rdat[1:0] !== 2'b10);
        t_preset;
        t_parallel;
        t_serial;
        stop_test;
    end
endmodule : fifo_reset_offset_program_tb
